// *** bench/rtcw_master.sv ***
// Two-wire bus master model: drives the clock, pulls data low or releases.
// Assumes the bench resolves data as a wired AND with a pull-up.
`timescale 1ns/1ns
module rtcw_master (
  input  wire logic i_clock, // System clock
  input  wire logic i_sda,   // Resolved data level
  output logic      o_scl,   // Bus clock level
  output logic      o_pull   // High pulls data low
);
  initial begin
    o_scl  = 1'b1; // Idle bus high
    o_pull = 1'b0;
  end
  // Wait whole cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc
  // One bit: data set with clock low, sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    o_pull <= ~b;
    cyc(4);
    o_scl <= 1'b1;
    cyc(4);
    r = i_sda;
    o_scl <= 1'b0;
  endtask : bit_x
  // Start: data falls under a high clock
  task automatic start;
    o_pull <= 1'b0;
    cyc(4);
    o_scl <= 1'b1;
    cyc(4);
    o_pull <= 1'b1;
    cyc(4);
    o_scl <= 1'b0;
    cyc(4);
  endtask : start
  // Stop: data rises under a high clock
  task automatic stop;
    o_pull <= 1'b1;
    cyc(4);
    o_scl <= 1'b1;
    cyc(4);
    o_pull <= 1'b0;
    cyc(4);
  endtask : stop
  // Byte out, MSB first; data released for the ack bit
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = (r === 1'b0);
  endtask : send
  // Byte in, then ack low or no-ack high
  task automatic recv(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, r);
  endtask : recv
  // Bus recovery: start, 63 released clocks, stop
  task automatic recover;
    logic r;
    start();
    repeat (63) bit_x(1'b1, r);
    stop();
  endtask : recover
endmodule : rtcw_master

// *** bench/rtcw_port_assertions.sv ***
// Checker for the two-wire port pins and the 1 Hz output of rtcw_port.
// Assumes one clock domain and a bind onto every rtcw_port instance.
`timescale 1ns/1ns
module rtcw_port_checker (
  input wire logic i_clock,          // System clock
  input wire logic i_rst_n,          // Synchronous reset, low
  input wire logic i_scl,            // Bus clock level
  input wire logic i_sda_in,         // Resolved data level
  input wire logic o_sda_oe,         // Device pulls data low
  input wire logic o_busy,           // Access in progress
  input wire logic o_wr_stb,         // Received byte pulse
  input wire logic o_rd_stb,         // Byte fetched pulse
  input wire logic o_rd_mode,        // Access is a read
  input wire logic i_half_tick,      // Plain half-second pulse
  input wire logic i_half_tick_corr, // Corrected half pulse
  input wire logic o_second_irq_pin  // 1 Hz output level
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Data falling under a high clock opens an access
  property p_start;
    i_scl && $past(i_scl) && $fell(i_sda_in) |=> o_busy;
  endproperty
  a_start: assert property (p_start)
    else $error("busy missing after start");
  // Data rising under a high clock closes it
  property p_stop;
    i_scl && $past(i_scl) && $rose(i_sda_in) |=> !o_busy;
  endproperty
  a_stop: assert property (p_stop)
    else $error("busy kept after stop");
  // Device drive changes only with the clock low
  property p_drive_low_clk;
    $changed(o_sda_oe) |-> !i_scl;
  endproperty
  a_drive_low_clk: assert property (p_drive_low_clk)
    else $error("data drive moved with clock high");
  // Write ack released one cycle after the ninth fall
  property p_ack_release;
    $fell(i_scl) && o_sda_oe && !o_rd_mode |=> !o_sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("ack held past ninth clock");
  // While the device holds data low the access stays open
  property p_hold_state;
    o_sda_oe |=> o_busy;
  endproperty
  a_hold_state: assert property (p_hold_state)
    else $error("access dropped while driving low");
  // Write strobe comes with the ack, only in write mode
  property p_wr_ack;
    o_wr_stb |-> !o_rd_mode && o_busy ##[0:1] o_sda_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write byte without ack");
  // Fetch strobe only in read mode
  property p_rd_mode;
    o_rd_stb |-> o_rd_mode && o_busy;
  endproperty
  a_rd_mode: assert property (p_rd_mode)
    else $error("fetch outside read mode");
  // 1 Hz output moves only after a half tick
  property p_pin_tick;
    $changed(o_second_irq_pin)
      |-> $past(i_half_tick) || $past(i_half_tick_corr);
  endproperty
  a_pin_tick: assert property (p_pin_tick)
    else $error("1 Hz output moved without tick");
endmodule : rtcw_port_checker

bind rtcw_port rtcw_port_checker rtcw_port_checker_inst (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(i_scl),
  .i_sda_in(i_sda_in), .o_sda_oe(o_sda_oe), .o_busy(o_busy),
  .o_wr_stb(o_wr_stb), .o_rd_stb(o_rd_stb), .o_rd_mode(o_rd_mode),
  .i_half_tick(i_half_tick), .i_half_tick_corr(i_half_tick_corr),
  .o_second_irq_pin(o_second_irq_pin)
);

// *** bench/rtcw_port_bench.sv ***
// Self-checking bench for rtcw_port, driven through the master model.
// Assumes rtcw_master, the checker bind and rtcw_pkg are compiled first.
`timescale 1ns/1ns
module rtcw_port_bench;
  import rtcw_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, ack, busy, oe, pin, pin_d;
  logic       scl, pull, sda, rd_mode, wr_stb, rd_stb, meas = 1'b0;
  logic       sda_out;
  logic       corr_act = 1'b0, corr_sel = 1'b0, ht = 1'b0, htc = 1'b0;
  logic [1:0] int_mode = 2'h0;
  logic [2:0] reg_sel, byte_idx, cmd;
  logic [3:0] tick = 4'h0;
  logic [7:0] rd_data = 8'h0, wr_data, last_wr = 8'h0, d, e;
  int         errors = 0, n_checks = 0, cyc_n = 0, gap = 0, odd, tog;
  int         n_rd = 0, n_wr = 0, rd0;
  int         lens[3] = '{1, 3, 2}; // Int register bytes per mode
  assign sda = ~pull & (oe ? sda_out : 1'b1); // Open drain, pull-up
  always #5 clk = ~clk;
  rtcw_master rtcw_master_inst (.i_clock(clk), .i_sda(sda), .o_scl(scl),
    .o_pull(pull));
  rtcw_port rtcw_port_inst (.i_clock(clk), .i_rst_n(rst_n), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(oe), .i_int_mode(int_mode),
    .i_rd_data(rd_data), .o_reg_sel(reg_sel), .o_byte_idx(byte_idx),
    .o_rd_mode(rd_mode), .o_wr_data(wr_data), .o_wr_stb(wr_stb),
    .o_rd_stb(rd_stb), .o_busy(busy), .i_corr_active(corr_act),
    .i_corr_interval_select(corr_sel), .i_half_tick(ht),
    .i_half_tick_corr(htc), .o_second_irq_pin(pin));
  // Register file stand-in, written bytes, half ticks, toggle gaps
  always @(posedge clk) begin
    rd_data <= {reg_sel, byte_idx, 2'b01};
    if (wr_stb === 1'b1) last_wr <= wr_data;
    if (wr_stb === 1'b1) n_wr <= n_wr + 1;
    if (rd_stb === 1'b1) n_rd <= n_rd + 1;
    tick <= tick + 4'h1;
    ht <= (tick == 4'h0);
    htc <= (tick == 4'h4); // Corrected tick four cycles late
    pin_d <= pin;
    gap <= gap + 1;
    if (!meas) begin
      tog <= 0;
      odd <= 0;
    end else if (pin !== pin_d) begin
      gap <= 1;
      if (tog > 0 && gap != 16) odd <= odd + 1; // Off-nominal gap
      tog <= tog + 1;
    end
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin // Hang guard
      errors++;
      summarize();
    end
  end
  // Compare a design value
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Compare a count
  task automatic chk_n(input string n, input int e, input int g);
    n_checks++;
    if (g != e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_n
  // Reset held for 12 cycles
  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : reset_dut
  // Verdict and end of run
  task automatic summarize;
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    reset_dut();
    chk("busy", 8'h0, busy);
    chk("sda out", 8'h0, sda_out);
    rtcw_master_inst.recover();
    chk("busy", 8'h0, busy);
    for (int c = 0; c < 2; c++) begin // Status one then two
      rtcw_master_inst.start();
      rtcw_master_inst.send({RTCW_DEV_CODE, c[2:0], 1'b0}, ack);
      chk("addr ack", 8'h1, ack);
      rtcw_master_inst.send(8'h5a + c[7:0], ack);
      chk("data ack", 8'h1, ack);
      chk("wr data", 8'h5a + c[7:0], last_wr);
      chk("sel", c[7:0], reg_sel);
      rtcw_master_inst.send(8'h33, ack);
      chk("extra ack", 8'h0, ack);
      rtcw_master_inst.stop();
      chk("busy", 8'h0, busy);
    end
    d = {~RTCW_DEV_CODE, RTCW_CMD_STAT1, 1'b0};
    rtcw_master_inst.start();
    rtcw_master_inst.send(d, ack);
    chk("bad code ack", 8'h0, ack);
    rtcw_master_inst.stop();
    // Abort a write mid-byte with a repeated start
    d = {RTCW_DEV_CODE, RTCW_CMD_STAT1, 1'b0};
    rtcw_master_inst.start();
    rtcw_master_inst.send(d, ack);
    repeat (4) rtcw_master_inst.bit_x(1'b0, ack);
    d = {RTCW_DEV_CODE, RTCW_CMD_STAT1, 1'b1};
    rtcw_master_inst.start();
    rtcw_master_inst.send(d, ack);
    chk("read ack", 8'h1, ack);
    rtcw_master_inst.recv(1'b0, d);
    chk("read byte", 8'h01, d);
    chk("rd mode", 8'h1, rd_mode);
    chk("wr kept", 8'h5b, last_wr);
    chk_n("wr count", 2, n_wr);
    rtcw_master_inst.stop();
    for (int md = 0; md < 3; md++) begin // Plain, alarm, frequency
      int_mode <= md[1:0];
      cmd = {2'b10, md[0]};
      rd0 = n_rd;
      rtcw_master_inst.start();
      rtcw_master_inst.send({RTCW_DEV_CODE, cmd, 1'b1}, ack);
      chk("int ack", 8'h1, ack);
      for (int k = 0; k < 3; k++) begin
        rtcw_master_inst.recv(k < 2, d);
        e = k < lens[md] ? {cmd, k[2:0], 2'b01} : 8'hff;
        chk("int byte", e, d);
      end
      chk("int sel", {5'h0, cmd}, reg_sel);
      rtcw_master_inst.stop();
      chk_n("rd stb", lens[md], n_rd - rd0);
    end
    // Read whose first bit is low, then a stop to be ignored
    d = {RTCW_DEV_CODE, RTCW_CMD_STAT1, 1'b1};
    rtcw_master_inst.start();
    rtcw_master_inst.send(d, ack);
    rtcw_master_inst.stop();
    chk("busy held", 8'h1, busy);
    rtcw_master_inst.recover();
    chk("busy freed", 8'h0, busy);
    chk("oe freed", 8'h0, oe);
    for (int s = 0; s < 2; s++) begin // Intervals 20 and 60
      corr_act <= 1'b1;
      corr_sel <= s[0];
      reset_dut();
      meas <= 1'b1;
      repeat (4000) @(posedge clk);
      chk_n("odd gaps", s ? 4 : 12, odd);
      meas <= 1'b0;
    end
    summarize();
  end
endmodule : rtcw_port_bench

// *** hdl/rtcw_corr.sv ***
// Drives the 1 Hz clock output and shortens one cycle per interval.
// Assumes half-second ticks, plain and corrected, from the divider.
`timescale 1ns/1ns
module rtcw_corr (
  input  wire logic i_clock,          // System clock
  input  wire logic i_rst_n,          // Synchronous reset, low
  input  wire logic i_corr_active,    // Correction in use
  input  wire logic i_interval_sel,   // Interval select bit
  input  wire logic i_half_tick,      // Plain half-second pulse
  input  wire logic i_half_tick_corr, // Corrected half-second pulse
  output logic      o_pin             // 1 Hz output level
);
  import rtcw_pkg::*;

  logic [5:0] cyc_r;   // Cycles since last corrected one
  logic [5:0] limit;   // Current interval length
  logic       corr_cyc; // This cycle is the corrected one
  logic       tick;    // Selected half tick

  // Interval chosen by select bit
  assign limit    = i_interval_sel ? RTCW_CORR_FINE
                                   : RTCW_CORR_COARSE;
  // Last cycle of each interval takes corrected timing
  assign corr_cyc = i_corr_active && (cyc_r == limit - 6'h1);
  assign tick     = corr_cyc ? i_half_tick_corr : i_half_tick;

  // Toggle on each half tick
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pin <= 1'b0;
    end else if (tick) begin
      o_pin <= ~o_pin;
    end
  end

  // Count whole cycles at each falling toggle
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cyc_r <= 6'h0;
    end else if (!i_corr_active) begin
      cyc_r <= 6'h0;
    end else if (tick && o_pin) begin
      if (cyc_r >= limit - 6'h1) begin
        cyc_r <= 6'h0;
      end else begin
        cyc_r <= cyc_r + 6'h1;
      end
    end
  end

endmodule : rtcw_corr

// *** hdl/rtcw_pkg.sv ***
// Constants and types for the two-wire command port of the calendar clock.
// Assumes one 100 MHz clock and bus pins sampled synchronously.
// Function
// - SDA falls while SCL high: access starts
// - SDA rises while SCL high: back to standby
// - SDA change during SCL high aborts transfer
// - Device pulls SDA low on ninth clock
// - No acknowledge when access is irregular
// - Device code, command, read bit one: read
// - Read bytes driven most significant bit first
// - Read/write bit zero: write, MSB first
// - Write: ack each byte, stop after last ack; code refuses bytes past the register end
// - Status select bit picks status one or two
// - Interrupt select bit picks register one or two
// - Interrupt register length follows status two mode
// - Interrupted transfer keeps state until stop
// - Stop ignored while device drives SDA low
// - Correction alters one 1 Hz cycle periodically
// - Interval select: 20 or 60 seconds
package rtcw_pkg;

  // Device code in the first byte; value arbitrary
  localparam logic [3:0] RTCW_DEV_CODE  = 4'ha;

  // First byte field positions
  localparam int         RTCW_CODE_HI   = 7;
  localparam int         RTCW_CODE_LO   = 4;
  localparam int         RTCW_CMD_HI    = 3;
  localparam int         RTCW_CMD_LO    = 1;
  localparam int         RTCW_RW_BIT    = 0;

  // Command field values; low bit is the select bit
  localparam logic [2:0] RTCW_CMD_STAT1 = 3'h0;
  localparam logic [2:0] RTCW_CMD_STAT2 = 3'h1;
  localparam logic [2:0] RTCW_CMD_RT1   = 3'h2;
  localparam logic [2:0] RTCW_CMD_RT2   = 3'h3;
  localparam logic [2:0] RTCW_CMD_FIRST_IRQ_REGISTER  = 3'h4;
  localparam logic [2:0] RTCW_CMD_SECOND_IRQ_PIN  = 3'h5;
  localparam logic [2:0] RTCW_CMD_CORR  = 3'h6;
  localparam logic [2:0] RTCW_CMD_FREE  = 3'h7;

  // Interrupt mode set in status register two
  localparam logic [1:0] RTCW_MODE_PLAIN = 2'h0;
  localparam logic [1:0] RTCW_MODE_ALARM = 2'h1;
  localparam logic [1:0] RTCW_MODE_FREQ  = 2'h2;

  // Register lengths in bytes
  localparam logic [2:0] RTCW_LEN_RT1   = 3'h7;
  localparam logic [2:0] RTCW_LEN_RT2   = 3'h3;
  localparam logic [2:0] RTCW_LEN_ALARM = 3'h3;
  localparam logic [2:0] RTCW_LEN_FREQ  = 3'h2;
  localparam logic [2:0] RTCW_LEN_ONE   = 3'h1;
  localparam logic [2:0] RTCW_IDX_MAX   = 3'h7;

  // Bit counter marks
  localparam logic [3:0] RTCW_BIT_LAST  = 4'h7;
  localparam logic [3:0] RTCW_BIT_FULL  = 4'h8;

  // Filler shifted out past the end of a register
  localparam logic [7:0] RTCW_IDLE_BYTE = 8'hff;

  // Correction intervals in 1 Hz cycles
  localparam logic [5:0] RTCW_CORR_COARSE = 6'h14;
  localparam logic [5:0] RTCW_CORR_FINE   = 6'h3c;

  // Port sequencing states
  typedef enum logic [3:0] {
    RTCW_IDLE, RTCW_ADDR, RTCW_ACK_ADDR, RTCW_WR, RTCW_ACK_DATA,
    RTCW_RD, RTCW_MACK, RTCW_RD_NEXT, RTCW_HALT
  } rtcw_state_t;

endpackage : rtcw_pkg

// *** hdl/rtcw_port.sv ***
// Two-wire serial slave port of the calendar clock with 1 Hz output.
// Assumes SCL and SDA already synchronous to i_clock; register file
// outside answers i_rd_data for the selected register and byte index.
// Bus pins are plain levels; the data line is open drain, so the
// device only ever pulls it low and never drives it high.
`timescale 1ns/1ns
module rtcw_port #(
  parameter logic [3:0] DEV_CODE = rtcw_pkg::RTCW_DEV_CODE // Arbitrary
) (
  input  wire logic       i_clock,          // System clock, 100 MHz
  input  wire logic       i_rst_n,          // Synchronous reset, low
  input  wire logic       i_scl,            // Bus clock level
  input  wire logic       i_sda_in,         // Bus data level
  output logic            o_sda_out,        // Data drive value, low
  output logic            o_sda_oe,         // Data pulled low when high
  input  wire logic [1:0] i_int_mode,       // Status two interrupt mode
  input  wire logic [7:0] i_rd_data,        // Byte of selected register
  output logic [2:0]      o_reg_sel,        // Selected command
  output logic [2:0]      o_byte_idx,       // Byte index in register
  output logic            o_rd_mode,        // Access is a read
  output logic [7:0]      o_wr_data,        // Received byte
  output logic            o_wr_stb,         // Received byte pulse
  output logic            o_rd_stb,         // Byte fetched pulse
  output logic            o_busy,           // Access in progress
  input  wire logic       i_corr_active,    // Correction in use
  input  wire logic       i_corr_interval_select, // Interval select
  input  wire logic       i_half_tick,      // Plain half-second pulse
  input  wire logic       i_half_tick_corr, // Corrected half pulse
  output logic            o_second_irq_pin  // 1 Hz output level
);
  import rtcw_pkg::*;

  rtcw_state_t state_r;   // Sequencer state
  logic        scl_q;     // Previous clock level
  logic        sda_q;     // Previous data level
  logic [3:0]  bit_r;     // Bits handled in this byte
  logic [7:0]  shift_r;   // Byte shifter
  logic [2:0]  len;       // Bytes in selected register
  logic        in_range;  // Byte index within register
  logic [7:0]  fetch;     // Next byte to send
  logic        start_det; // Start seen
  logic        stop_det;  // Stop seen
  logic        scl_rise;  // Clock rising
  logic        scl_fall;  // Clock falling

  // Byte counts per command:
  //   time one 7, time two 3, status and the rest 1;
  //   interrupt pair 3 in alarm mode, 2 in frequency mode,
  //   1 otherwise. Bytes past the end read as all ones
  //   and are refused on write.
  // Register length by command and interrupt mode
  function automatic logic [2:0] rtcw_len(input logic [2:0] sel,
                                          input logic [1:0] mode);
    logic [2:0] n;
    n = RTCW_LEN_ONE;
    if (sel == RTCW_CMD_RT1) begin
      n = RTCW_LEN_RT1;
    end else if (sel == RTCW_CMD_RT2) begin
      n = RTCW_LEN_RT2;
    end else if (sel == RTCW_CMD_FIRST_IRQ_REGISTER || sel == RTCW_CMD_SECOND_IRQ_PIN) begin
      if (mode == RTCW_MODE_ALARM) begin
        n = RTCW_LEN_ALARM;
      end else if (mode == RTCW_MODE_FREQ) begin
        n = RTCW_LEN_FREQ;
      end
    end
    return n;
  endfunction : rtcw_len

  // Reset loads the idle bus levels, so the first samples
  // after release see no false edge and no false condition.
  // There is no bus reset pin: only a stop clears an access.
  // Previous pin levels for edge and condition detection
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda_in;
    end
  end

  // Conditions: data moves while clock stays high
  assign start_det = i_scl && scl_q && sda_q && !i_sda_in;
  assign stop_det  = i_scl && scl_q && !sda_q && i_sda_in;
  assign scl_rise  = i_scl && !scl_q;
  assign scl_fall  = !i_scl && scl_q;

  // Length and fetch for the current byte
  assign len      = rtcw_len(o_reg_sel, i_int_mode);
  assign in_range = (o_byte_idx < len);
  assign fetch    = in_range ? i_rd_data : RTCW_IDLE_BYTE;

  // Drive value is always low; only the enable moves
  always_ff @(posedge i_clock) begin
    o_sda_out <= 1'b0;
  end

  // State flow of one access:
  //   IDLE      nothing open; only a start leaves it
  //   ADDR      eight rises shift in code, command, direction
  //   ACK_ADDR  line held low through the ninth clock
  //   WR        eight rises shift in one write byte
  //   ACK_DATA  line held low through the ninth clock
  //   RD        one bit driven per falling clock, MSB first
  //   MACK      line released, master answers on ninth rise
  //   RD_NEXT   next byte loaded on the ninth fall
  //   HALT      access refused or read ended by master no-ack; waits for start or stop
  // Priority on each edge:
  //   stop with line released, then start, then state step.
  // A stop seen while the line is held low is dropped, so a
  // master that lost track must clock the device out of a
  // read or acknowledge first; 63 released clocks always do.
  // Drive changes one cycle after the sampled falling clock,
  // so the line only moves while the bus clock is low.
  // Timing of one received byte, in bus clocks:
  //   rises 1 to 8  sample data, MSB first
  //   fall 8        decide: pull low to accept, or refuse
  //   fall 9        release, or load the next read byte
  // Timing of one sent byte:
  //   fall 9 before  drive bit 7
  //   falls 1 to 7   drive bits 6 to 0
  //   fall 8         release for the master answer
  //   rise 9         low answer continues, high ends
  // Sequencer, shifter and data drive
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r  <= RTCW_IDLE;
      bit_r    <= 4'h0;
      shift_r  <= 8'h0;
      o_sda_oe <= 1'b0;
    end else if (stop_det && !o_sda_oe) begin
      // Stop only counts while the line is released
      state_r  <= RTCW_IDLE;
      o_sda_oe <= 1'b0;
    end else if (start_det) begin
      // Start or repeated start aborts and restarts
      state_r  <= RTCW_ADDR;
      bit_r    <= 4'h0;
      o_sda_oe <= 1'b0;
    end else begin
      case (state_r)
        // Receiving first byte or write data, MSB first
        RTCW_ADDR, RTCW_WR: begin
          if (scl_rise && bit_r != RTCW_BIT_FULL) begin
            shift_r <= {shift_r[6:0], i_sda_in};
            bit_r   <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == RTCW_BIT_FULL) begin
            if (state_r == RTCW_ADDR) begin
              if (shift_r[RTCW_CODE_HI:RTCW_CODE_LO] == DEV_CODE) begin
                o_sda_oe <= 1'b1;
                state_r  <= RTCW_ACK_ADDR;
              end else begin
                state_r  <= RTCW_HALT;
              end
            end else if (in_range) begin
              o_sda_oe <= 1'b1;
              state_r  <= RTCW_ACK_DATA;
            end else begin
              state_r  <= RTCW_HALT;
            end
          end
        end
        // Acknowledge after the device code
        RTCW_ACK_ADDR: begin
          if (scl_fall) begin
            bit_r <= 4'h0;
            if (o_rd_mode) begin
              shift_r  <= fetch;
              o_sda_oe <= !fetch[7];
              state_r  <= RTCW_RD;
            end else begin
              o_sda_oe <= 1'b0;
              state_r  <= RTCW_WR;
            end
          end
        end
        // Acknowledge after a write byte
        RTCW_ACK_DATA: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b0;
            bit_r    <= 4'h0;
            state_r  <= RTCW_WR;
          end
        end
        // Shift read data out on each falling clock
        RTCW_RD: begin
          if (scl_fall) begin
            if (bit_r == RTCW_BIT_LAST) begin
              o_sda_oe <= 1'b0; // Free line for master ack
              state_r  <= RTCW_MACK;
            end else begin
              o_sda_oe <= !shift_r[6];
              shift_r  <= {shift_r[6:0], 1'b1};
              bit_r    <= bit_r + 4'h1;
            end
          end
        end
        // Master ack low continues, high ends the read
        RTCW_MACK: begin
          if (scl_rise) begin
            if (!i_sda_in) begin
              state_r <= RTCW_RD_NEXT;
            end else begin
              state_r <= RTCW_HALT;
            end
          end
        end
        // Present next byte of the register
        RTCW_RD_NEXT: begin
          if (scl_fall) begin
            bit_r    <= 4'h0;
            shift_r  <= fetch;
            o_sda_oe <= !fetch[7];
            state_r  <= RTCW_RD;
          end
        end
        // Idle and halted wait for a condition
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Command and direction latch only on a matching code;
  // a refused first byte leaves the last selection.
  // Index steps on each accepted byte and stops at its top,
  // so a long burst keeps reading the filler byte.
  // Command, direction and byte index
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_reg_sel  <= RTCW_CMD_STAT1;
      o_rd_mode  <= 1'b0;
      o_byte_idx <= 3'h0;
    end else if (state_r == RTCW_ADDR && scl_fall
                 && bit_r == RTCW_BIT_FULL && !start_det
                 && shift_r[RTCW_CODE_HI:RTCW_CODE_LO] == DEV_CODE) begin
      // Low command bit selects register one or two
      o_reg_sel  <= shift_r[RTCW_CMD_HI:RTCW_CMD_LO];
      o_rd_mode  <= shift_r[RTCW_RW_BIT];
      o_byte_idx <= 3'h0;
    end else if (!start_det && !stop_det) begin
      if ((state_r == RTCW_MACK && scl_rise && !i_sda_in)
          || (state_r == RTCW_ACK_DATA && scl_fall)) begin
        if (o_byte_idx != RTCW_IDX_MAX) begin
          o_byte_idx <= o_byte_idx + 3'h1;
        end
      end
    end
  end

  // Strobes are single cycle; a start, or a stop with the line
  // released, on the same edge cancels them, so no half byte escapes.
  // Write data and strobes toward the register file
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wr_data <= 8'h0;
      o_wr_stb  <= 1'b0;
      o_rd_stb  <= 1'b0;
    end else begin
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      if (!start_det && !(stop_det && !o_sda_oe)) begin
        if (state_r == RTCW_WR && scl_fall
            && bit_r == RTCW_BIT_FULL && in_range) begin
          o_wr_data <= shift_r;
          o_wr_stb  <= 1'b1;
        end
        if (scl_fall && in_range && (state_r == RTCW_RD_NEXT
            || (state_r == RTCW_ACK_ADDR && o_rd_mode))) begin
          o_rd_stb  <= 1'b1;
        end
      end
    end
  end

  // Same stop rule as the sequencer: a stop masked by the
  // held line keeps the access open.
  // Busy from start until stop
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
    end else if (stop_det && !o_sda_oe) begin
      o_busy <= 1'b0;
    end else if (start_det) begin
      o_busy <= 1'b1;
    end
  end

  // One 1 Hz cycle per interval takes the corrected timing;
  // the divider outside supplies both half-tick pulses.
  // 1 Hz output with periodic correction
  rtcw_corr u_corr (
    .i_clock          (i_clock),
    .i_rst_n          (i_rst_n),
    .i_corr_active    (i_corr_active),
    .i_interval_sel   (i_corr_interval_select),
    .i_half_tick      (i_half_tick),
    .i_half_tick_corr (i_half_tick_corr),
    .o_pin            (o_second_irq_pin)
  );

endmodule : rtcw_port
